// ### pkg/adc_scan_params.svh
// offsets, field positions, reset values and timing counts of the scan board
`ifndef ADC_SCAN_PARAMS_SVH
`define ADC_SCAN_PARAMS_SVH
// register byte offsets within the 4 KiB board window
`define OFS_CTRL_STATUS 12'h002
`define OFS_CONFIG      12'h004
`define OFS_RATE        12'h006
`define OFS_IRQ_CTRL    12'h008
`define OFS_RESET_CMD   12'h00c
`define OFS_TRIG_CMD    12'h00e
`define OFS_IRQ_VECTOR  12'h010
`define OFS_GAIN_ENTRY  12'h012
`define OFS_COUNT0      12'h020
`define OFS_COUNT1      12'h022
`define OFS_CHAN_COUNT  12'h024
`define OFS_TIMER_CTRL  12'h026
`define OFS_BUFFER      12'h080
// reset values
`define RST_CTRL_STATUS 16'h0000
`define RST_CONFIG      16'h5800
`define RST_RATE        16'h007a
`define RST_IRQ_CTRL    16'hff00
`define RST_IRQ_VECTOR  16'hff00
// field positions
`define TRIG_HI_BIT   13
`define TRIG_LO_BIT   12
`define TWOS_BIT      11
`define HALF_BIT      10
`define READY_BIT     6
`define MODE_HI_BIT   7
`define MODE_LO_BIT   6
`define AUTO_GAIN_BIT 9
`define FIX_X10_BIT   8
`define IRQ_EN_BIT    0
`define IRQ_CNT_BIT   1
`define IRQ_LEVEL     3'h1
// timing
`define CLK_PERIOD_NS 8
`define RATE_UNIT_NS  80
`define RATE_UNIT_CYC (`RATE_UNIT_NS / `CLK_PERIOD_NS)
`define RATE_OFFSET   3
`define TICK_NS       160
`define TICK_CYC      (`TICK_NS / `CLK_PERIOD_NS)
`define STRETCH_NS    250
`define STRETCH_CYC   ((`STRETCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ### pkg/adc_scan_pkg.sv
// state and mode types of the scan board
package adc_scan_pkg;
	typedef enum logic [2:0] {
		SCAN_IDLE  = 3'b001,
		SCAN_RUN   = 3'b010,
		SCAN_WRITE = 3'b100
	} scan_state_t;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} bus_state_t;
	typedef enum logic [1:0] {
		TRIG_SOFT  = 2'b00,
		TRIG_EXT   = 2'b01,
		TRIG_TIMER = 2'b10
	} trig_mode_t;
endpackage

// ### design/interval_timer.sv
// triple counter: two cascaded interval counters and a channel counter
`timescale 1ns/10ps
`include "adc_scan_params.svh"
module interval_timer (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        ctl_wr,
	input  wire logic [2:0]  cnt_wr,
	input  wire logic [7:0]  wr_byte,
	input  wire logic        run,
	input  wire logic        update,
	output logic             expire,
	output logic             chan_done,
	output logic [15:0]      count0,
	output logic [15:0]      count1,
	output logic [15:0]      count2
);
	import adc_scan_pkg::*;
	logic [15:0] reload [0:2];
	logic [15:0] cnt [0:2];
	logic [2:0]  hi_next;
	logic [4:0]  tick;
	logic        tick_evt;
	logic        c0_evt;
	logic        run_d;

	// a count of one or zero reloads, so a period is the loaded value
	function automatic logic [15:0] step(input logic [15:0] c, input logic [15:0] r);
		return (c <= 16'h0001) ? r : c - 16'h0001;
	endfunction

	// ------------------------------
	// 160 ns time base
	// ------------------------------
	always_ff @(posedge core_clk) begin
		if (srst || !run)
			tick <= 5'h00;
		else if (tick == 5'(`TICK_CYC - 1))
			tick <= 5'h00;
		else
			tick <= tick + 5'h01;
	end
	assign tick_evt = run && (tick == 5'(`TICK_CYC - 1));
	assign c0_evt = tick_evt && (cnt[0] <= 16'h0001);

	// ------------------------------
	// load path: control word, then low byte, then high byte
	// ------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			hi_next <= 3'h0;
			for (int i = 0; i < 3; i++)
				reload[i] <= 16'h0000;
		end else begin
			if (ctl_wr && wr_byte[7:6] != 2'h3)
				hi_next[wr_byte[7:6]] <= 1'b0;
			for (int i = 0; i < 3; i++) begin
				if (cnt_wr[i]) begin
					if (hi_next[i])
						reload[i][15:8] <= wr_byte;
					else
						reload[i][7:0] <= wr_byte;
					hi_next[i] <= ~hi_next[i];
				end
			end
		end
	end

	// ------------------------------
	// counting; counter 1 is clocked by counter 0 running out
	// ------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			run_d <= 1'b0;
			for (int i = 0; i < 3; i++)
				cnt[i] <= 16'h0000;
		end else begin
			run_d <= run;
			if (run && !run_d) begin
				cnt[0] <= reload[0];
				cnt[1] <= reload[1];
			end else begin
				if (tick_evt)
					cnt[0] <= step(cnt[0], reload[0]);
				if (c0_evt)
					cnt[1] <= step(cnt[1], reload[1]);
			end
			if (cnt_wr[2] && hi_next[2])
				cnt[2] <= {wr_byte, reload[2][7:0]};
			else if (update)
				cnt[2] <= step(cnt[2], reload[2]);
		end
	end

	// event pulses, registered so they leave on a clean edge
	always_ff @(posedge core_clk) begin
		if (srst) begin
			expire    <= 1'b0;
			chan_done <= 1'b0;
		end else begin
			expire    <= c0_evt && (cnt[1] <= 16'h0001);
			chan_done <= update && (cnt[2] == 16'h0001) && !(cnt_wr[2] && hi_next[2]);
		end
	end
	assign count0 = cnt[0];
	assign count1 = cnt[1];
	assign count2 = cnt[2];
endmodule // interval_timer

// ### design/vme_adc_scan_control.sv
// bus slave, registers, buffers and scan sequencer of the converter board
`timescale 1ns/10ps
`include "adc_scan_params.svh"
// Behaviour
// - master trigger output feeds external start of up to 16 slave boards
// - interrupt on data ready or channel counter expiry when enabled
// - system reset loads interrupt control and vector with ff00
// - reset command: auto scan, 100 kHz, interrupts off, ready at end
// - software trigger command starts the scan in software trigger mode
// - scan rate 381 Hz to 4.17 MHz set by the rate register
// - interrupt control ff00 disables, ff01 enables level 1 requests
// - per-channel gain buffer, code 0 unity, 1 gain ten
// - reading the first buffer word clears the data ready bit
// - two cascaded counters, loaded low then high byte, 160 ns tick
// - e800 selects timer trigger, two's complement; 8000 software, offset
// - configuration 588f: random access channel 15, unity, first word
// - 4002 auto scan 64/8 channels 16-23; 0240 single, auto gain
// - accept only on address and modifier match, acknowledge until end
// - interrupt acknowledge cycle answered with acknowledge and vector
// - decode A15..A12, A23..A12, A31..A12 for short, standard, extended space; byte and word
// - single-ported data buffer shared by bus and scan logic
// - external mode starts on a falling edge of the start input; a low shorter than one 8 ns clock can be missed
// - status bits 13:12 select software, external or timer trigger
// - configuration bits 7:6 select auto, single or random access
// - converter holding buffer stretches bus access; bus access delays converter
module vme_adc_scan_control (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        as_n,
	input  wire logic        ds0_n,
	input  wire logic        ds1_n,
	input  wire logic        write_n,
	input  wire logic        iack_n,
	input  wire logic        iackin_n,
	input  wire logic [5:0]  am,
	input  wire logic [31:1] addr,
	input  wire logic [15:0] data_in,
	input  wire logic [19:0] addr_jumpers,
	input  wire logic [5:0]  am_jumpers,
	input  wire logic        external_start_input_n,
	input  wire logic [15:0] adc_result,
	output logic [15:0]      data_out,
	output logic             data_oe,
	output logic             dtack_n_out,
	output logic             dtack_oe,
	output logic             irq1_n_out,
	output logic             irq1_oe,
	output logic             iackout_n,
	output logic             sync_trigger_output_n,
	output logic [5:0]       mux_channel,
	output logic             gain_x10,
	output logic             sample_strobe
);
	import adc_scan_pkg::*;
	logic [85:0] pin_m, pin_s;
	logic        s_as_n, s_ds0_n, s_ds1_n, s_write_n, s_iack_n, s_iackin_n, s_ext_n;
	logic [5:0]  s_am, s_am_jump;
	logic [31:1] s_addr;
	logic [15:0] s_data;
	logic [19:0] s_jump, amask;
	logic [1:0]  be;
	logic [11:0] acc_off;
	logic [10:0] ram_idx;
	logic        ds_act, is_ram, board_sel, iack_sel, bus_go, wr_go, rd_go;
	logic        acc_wr, own_iack, conv_grant;
	logic        w_status, w_config, w_rate, w_irq, w_reset, w_trig, w_vec, w_gain;
	logic        soft_rst, cmd_done, ready_flag, ready_evt, irq_pend;
	logic [15:0] ctrl_status, cfg, rate, irq_ctrl, irq_vector;
	logic [63:0] gain_ram;
	logic [15:0] ram [0:2047];
	logic [15:0] conv_data, count0, count1, count2;
	logic [5:0]  hold, trig_cnt, ch_cnt;
	logic [9:0]  wptr;
	logic [18:0] period_cnt, period_len;
	logic        s_ext_d, ext_fall, trig_evt, timer_expire, chan_done;
	logic        random, single, start, blk_last, buf_last, buf_half, next_end;
	trig_mode_t  trig_mode;
	bus_state_t  bus_state;
	scan_state_t scan_state;

	function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] d,
		input logic [1:0] b);
		return {b[1] ? d[15:8] : o[15:8], b[0] ? d[7:0] : o[7:0]};
	endfunction
	// block size log2; a 16-word buffer with code 0 holds one 16-channel block
	function automatic logic [2:0] blk_log(input logic [15:0] c);
		return (c[12:11] == 2'h0 && !c[14]) ? 3'd4 : 3'(3 + c[12:11]);
	endfunction
	function automatic logic [3:0] buf_log(input logic [15:0] c);
		return 4'(4 + 2 * c[15:14]);
	endfunction
	function automatic logic [5:0] chan_of(input logic [15:0] c, input logic [5:0] i);
		return c[`MODE_HI_BIT] ? c[5:0] : 6'(({3'h0, c[2:0]} << blk_log(c)) + i);
	endfunction
	function automatic logic gain_of(input logic [15:0] c, input logic [63:0] g,
		input logic [5:0] ch);
		return c[`AUTO_GAIN_BIT] ? g[ch] : c[`FIX_X10_BIT];
	endfunction

	// ------------------------------
	// pin synchronisers
	// ------------------------------
	// every pin except adc_result passes two flops; only the second stage is read below
	always_ff @(posedge core_clk) begin
		if (srst) begin
			pin_m <= '1;
			pin_s <= '1;
		end else begin
			pin_m <= {as_n, ds0_n, ds1_n, write_n, iack_n, iackin_n, external_start_input_n,
				am, addr, data_in, addr_jumpers, am_jumpers};
			pin_s <= pin_m;
		end
	end
	assign {s_as_n, s_ds0_n, s_ds1_n, s_write_n, s_iack_n, s_iackin_n, s_ext_n,
		s_am, s_addr, s_data, s_jump, s_am_jump} = pin_s;

	// ------------------------------
	// board selection and transfer handshake
	// ------------------------------
	assign ds_act  = !s_ds0_n || !s_ds1_n;
	assign be      = {!s_ds1_n, !s_ds0_n};
	assign acc_off = {s_addr[11:1], 1'b0};
	assign ram_idx = s_addr[11:1];
	assign is_ram  = acc_off >= `OFS_BUFFER;
	// short space compares A15..A12, standard A23..A12, extended all
	assign amask = (s_am[5:4] == 2'h2) ? 20'h0000f : (s_am[5:4] == 2'h3) ? 20'h00fff : 20'hfffff;
	assign board_sel = !s_as_n && s_iack_n && (s_am == s_am_jump)
		&& (((s_addr[31:12] ^ s_jump) & amask) == 20'h00000);
	assign iack_sel = !s_as_n && !s_iack_n && !s_iackin_n && irq_pend
		&& (s_addr[3:1] == `IRQ_LEVEL);
	// the converter wins a tie; a buffer access then waits out the hold time
	assign conv_grant = (scan_state == SCAN_WRITE) && (bus_state == BUS_IDLE);
	assign bus_go = (bus_state == BUS_IDLE) && ds_act && (board_sel || iack_sel)
		&& !(is_ram && !iack_sel && (conv_grant || hold != 6'h00));
	assign wr_go = bus_go && !s_write_n && !iack_sel;
	assign rd_go = bus_go && s_write_n && !iack_sel;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			bus_state <= BUS_IDLE;
			acc_wr    <= 1'b0;
		end else begin
			unique case (bus_state)
				BUS_IDLE: if (bus_go) begin
					bus_state <= BUS_ACK;
					acc_wr    <= !s_write_n && !iack_sel;
				end
				BUS_ACK: if (!ds_act) bus_state <= BUS_IDLE;
			endcase
		end
	end
	assign dtack_n_out = 1'b0;
	assign dtack_oe    = bus_state == BUS_ACK;
	assign data_oe     = (bus_state == BUS_ACK) && !acc_wr;

	// converter hold time during which the buffer belongs to the scan side
	always_ff @(posedge core_clk) begin
		if (srst)
			hold <= 6'h00;
		else if (conv_grant)
			hold <= 6'(`STRETCH_CYC);
		else if (hold != 6'h00)
			hold <= hold - 6'h01;
	end

	// ------------------------------
	// register decode
	// ------------------------------
	assign w_status = wr_go && acc_off == `OFS_CTRL_STATUS;
	assign w_config = wr_go && acc_off == `OFS_CONFIG;
	assign w_rate   = wr_go && acc_off == `OFS_RATE;
	assign w_irq    = wr_go && acc_off == `OFS_IRQ_CTRL;
	assign w_reset  = wr_go && acc_off == `OFS_RESET_CMD;
	assign w_trig   = wr_go && acc_off == `OFS_TRIG_CMD;
	assign w_vec    = wr_go && acc_off == `OFS_IRQ_VECTOR;
	assign w_gain   = wr_go && acc_off == `OFS_GAIN_ENTRY && be[0];
	assign soft_rst = srst || w_reset;

	always_ff @(posedge core_clk) begin
		if (soft_rst)
			ctrl_status <= `RST_CTRL_STATUS;
		else if (w_status)
			ctrl_status <= merge(ctrl_status, s_data, be) & ~(16'h0001 << `READY_BIT);
	end
	always_ff @(posedge core_clk) begin
		if (soft_rst)
			cfg <= `RST_CONFIG;
		else if (w_config)
			cfg <= merge(cfg, s_data, be);
	end
	always_ff @(posedge core_clk) begin
		if (soft_rst)
			rate <= `RST_RATE;
		else if (w_rate)
			rate <= merge(rate, s_data, be);
	end
	always_ff @(posedge core_clk) begin
		if (soft_rst)
			irq_ctrl <= `RST_IRQ_CTRL;
		else if (w_irq)
			irq_ctrl <= merge(irq_ctrl, s_data, be);
	end
	always_ff @(posedge core_clk) begin
		if (srst)
			irq_vector <= `RST_IRQ_VECTOR;
		else if (w_vec)
			irq_vector <= merge(irq_vector, s_data, be);
	end
	// gain entries go to the slot named by the configuration channel field
	always_ff @(posedge core_clk) begin
		if (srst)
			gain_ram <= 64'h0;
		else if (w_gain)
			gain_ram[cfg[5:0]] <= s_data[0];
	end

	// status bit 6: data ready and command done share it; a set beats a read
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cmd_done   <= 1'b0;
			ready_flag <= 1'b0;
		end else begin
			cmd_done <= w_reset || w_config;
			if (ready_evt || cmd_done)
				ready_flag <= 1'b1;
			else if (rd_go && acc_off == `OFS_BUFFER)
				ready_flag <= 1'b0;
		end
	end

	// read data; write-only and command locations answer zero
	always_ff @(posedge core_clk) begin
		if (srst)
			data_out <= 16'h0000;
		else if (bus_go && iack_sel)
			data_out <= irq_vector;
		else if (rd_go) begin
			case (acc_off)
				`OFS_CTRL_STATUS: data_out <= ctrl_status | (16'(ready_flag) << `READY_BIT);
				`OFS_CONFIG:      data_out <= cfg;
				`OFS_RATE:        data_out <= rate;
				`OFS_IRQ_CTRL:    data_out <= irq_ctrl;
				`OFS_IRQ_VECTOR:  data_out <= irq_vector;
				`OFS_COUNT0:      data_out <= count0;
				`OFS_COUNT1:      data_out <= count1;
				`OFS_CHAN_COUNT:  data_out <= count2;
				default:          data_out <= is_ram ? ram[ram_idx] : 16'h0000;
			endcase
		end
	end

	// ------------------------------
	// shared data buffer
	// ------------------------------
	always_ff @(posedge core_clk) begin
		if (conv_grant)
			ram[11'(`OFS_BUFFER >> 1) + {1'b0, wptr}] <= conv_data;
		else if (wr_go && is_ram)
			ram[ram_idx] <= merge(ram[ram_idx], s_data, be);
	end

	// ------------------------------
	// trigger selection and scan sequencer
	// ------------------------------
	assign trig_mode = trig_mode_t'(ctrl_status[`TRIG_HI_BIT:`TRIG_LO_BIT]);
	assign ext_fall = s_ext_d && !s_ext_n;
	assign trig_evt = (trig_mode == TRIG_SOFT) ? w_trig :
		(trig_mode == TRIG_EXT) ? ext_fall : (trig_mode == TRIG_TIMER) && timer_expire;
	assign random = cfg[`MODE_HI_BIT];
	assign single = !cfg[`MODE_HI_BIT] && cfg[`MODE_LO_BIT];
	// auto scan needs no trigger and restarts on its own
	assign start = (scan_state == SCAN_IDLE) && ((random || single) ? trig_evt : 1'b1);
	assign blk_last = ch_cnt == 6'((7'h01 << blk_log(cfg)) - 7'h01);
	assign buf_last = wptr == 10'((11'h001 << buf_log(cfg)) - 11'h001);
	assign buf_half = wptr == 10'((11'h001 << (buf_log(cfg) - 4'h1)) - 11'h001);
	assign next_end = random || (single && blk_last);
	// channel period is (value + 3) units of 80 ns
	assign period_len = 19'(({4'h0, rate[14:0]} + 19'(`RATE_OFFSET)) * `RATE_UNIT_CYC);
	assign ready_evt = conv_grant && (random
		|| (ctrl_status[`HALF_BIT] ? buf_half : buf_last));

	always_ff @(posedge core_clk) begin
		if (srst)
			s_ext_d <= 1'b1;
		else
			s_ext_d <= s_ext_n;
	end

	always_ff @(posedge core_clk) begin
		if (soft_rst) begin
			scan_state    <= SCAN_IDLE;
			ch_cnt        <= 6'h00;
			wptr          <= 10'h000;
			period_cnt    <= 19'h0;
			mux_channel   <= 6'h00;
			gain_x10      <= 1'b0;
			sample_strobe <= 1'b0;
			conv_data     <= 16'h0000;
		end else begin
			sample_strobe <= 1'b0;
			unique case (scan_state)
				SCAN_IDLE: if (start) begin
					ch_cnt        <= 6'h00;
					mux_channel   <= chan_of(cfg, 6'h00);
					gain_x10      <= gain_of(cfg, gain_ram, chan_of(cfg, 6'h00));
					period_cnt    <= period_len;
					sample_strobe <= 1'b1;
					if (random)
						wptr <= 10'h000;
					scan_state <= SCAN_RUN;
				end
				SCAN_RUN: if (period_cnt <= 19'h1) begin
					conv_data  <= ctrl_status[`TWOS_BIT] ? {~adc_result[15], adc_result[14:0]}
						: adc_result;
					scan_state <= SCAN_WRITE;
				end else
					period_cnt <= period_cnt - 19'h1;
				// waits here while a bus transfer is in progress
				SCAN_WRITE: if (conv_grant) begin
					wptr <= (random || buf_last) ? 10'h000 : wptr + 10'h001;
					if (next_end)
						scan_state <= SCAN_IDLE;
					else begin
						ch_cnt        <= blk_last ? 6'h00 : ch_cnt + 6'h01;
						mux_channel   <= chan_of(cfg, blk_last ? 6'h00 : ch_cnt + 6'h01);
						gain_x10      <= gain_of(cfg, gain_ram,
							chan_of(cfg, blk_last ? 6'h00 : ch_cnt + 6'h01));
						period_cnt    <= period_len;
						sample_strobe <= 1'b1;
						scan_state    <= SCAN_RUN;
					end
				end
			endcase
		end
	end

	// low pulse of 250 ns on every scan start, for slave boards
	always_ff @(posedge core_clk) begin
		if (srst)
			trig_cnt <= 6'h00;
		else if (start || (conv_grant && blk_last && !next_end))
			trig_cnt <= 6'(`STRETCH_CYC);
		else if (trig_cnt != 6'h00)
			trig_cnt <= trig_cnt - 6'h01;
	end
	assign sync_trigger_output_n = trig_cnt == 6'h00;

	interval_timer i_interval_timer (
		.core_clk  (core_clk),
		.srst      (soft_rst),
		.ctl_wr    (wr_go && acc_off == `OFS_TIMER_CTRL && be[0]),
		.cnt_wr    ({3{be[0]}} & {wr_go && acc_off == `OFS_CHAN_COUNT,
			wr_go && acc_off == `OFS_COUNT1, wr_go && acc_off == `OFS_COUNT0}),
		.wr_byte   (s_data[7:0]),
		.run       (trig_mode == TRIG_TIMER),
		.update    (conv_grant),
		.expire    (timer_expire),
		.chan_done (chan_done),
		.count0    (count0),
		.count1    (count1),
		.count2    (count2)
	);

	// ------------------------------
	// bus interrupter
	// ------------------------------
	// a new event in the acknowledge cycle keeps the request standing
	always_ff @(posedge core_clk) begin
		if (soft_rst || !irq_ctrl[`IRQ_EN_BIT])
			irq_pend <= 1'b0;
		else if (ready_evt || (irq_ctrl[`IRQ_CNT_BIT] && chan_done))
			irq_pend <= 1'b1;
		else if (bus_go && iack_sel)
			irq_pend <= 1'b0;
	end
	always_ff @(posedge core_clk) begin
		if (srst) begin
			own_iack  <= 1'b0;
			iackout_n <= 1'b1;
		end else begin
			if (bus_go && iack_sel)
				own_iack <= 1'b1;
			else if (s_as_n)
				own_iack <= 1'b0;
			iackout_n <= !(!s_as_n && !s_iack_n && !s_iackin_n && !irq_pend && !own_iack
				&& bus_state == BUS_IDLE);
		end
	end
	assign irq1_n_out = 1'b0;
	assign irq1_oe    = irq_pend;
endmodule // vme_adc_scan_control

// ### verification/vme_adc_scan_control_assertions.sv
// port-level checks of the converter board control block
`timescale 1ns/10ps
module vme_adc_scan_control_assertions (
	input wire logic        core_clk,
	input wire logic        srst,
	input wire logic        as_n,
	input wire logic        ds0_n,
	input wire logic        ds1_n,
	input wire logic        write_n,
	input wire logic        iack_n,
	input wire logic        iackin_n,
	input wire logic [15:0] data_out,
	input wire logic        data_oe,
	input wire logic        dtack_oe,
	input wire logic        irq1_oe,
	input wire logic        iackout_n,
	input wire logic        sync_trigger_output_n,
	input wire logic        sample_strobe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	// pulse is too long for a repetition, so count its low cycles
	logic [7:0] low_cnt;
	always_ff @(posedge core_clk)
		low_cnt <= (srst || sync_trigger_output_n) ? 8'h00 : low_cnt + 8'h01;
	sequence s_released; ds0_n && ds1_n && dtack_oe; endsequence
	property p_ack_cause; $rose(dtack_oe) |-> !$past(as_n, 2) && !as_n; endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("acknowledge without address strobe");
	property p_ack_end; s_released |-> ##[1:5] !dtack_oe; endproperty
	a_ack_end: assert property (p_ack_end)
		else $error("acknowledge held after strobes released");
	property p_read_oe; data_oe |-> dtack_oe && write_n; endproperty
	a_read_oe: assert property (p_read_oe)
		else $error("read data driven outside a read");
	property p_data_hold; data_oe && $past(data_oe) |-> $stable(data_out); endproperty
	a_data_hold: assert property (p_data_hold)
		else $error("read data changed while driven");
	property p_trig_len; $rose(sync_trigger_output_n) |-> low_cnt == 8'h20; endproperty
	a_trig_len: assert property (p_trig_len)
		else $error("trigger pulse of wrong length");
	property p_trig_scan; $fell(sync_trigger_output_n) |-> ##[0:2] sample_strobe; endproperty
	a_trig_scan: assert property (p_trig_scan)
		else $error("trigger pulse without a scan start");
	property p_iack_vec; $rose(dtack_oe) && !iack_n |-> !irq1_oe && data_oe; endproperty
	a_iack_vec: assert property (p_iack_vec)
		else $error("interrupt acknowledge answered wrongly");
	property p_chain; $fell(iackout_n) |-> !iackin_n && !iack_n && !as_n; endproperty
	a_chain: assert property (p_chain)
		else $error("daisy chain passed outside an acknowledge");
	property p_reset; $past(srst) |-> !dtack_oe && !irq1_oe && iackout_n && !data_oe; endproperty
	a_reset: assert property (p_reset)
		else $error("bus outputs active out of reset");
endmodule // vme_adc_scan_control_assertions

// ### verification/vme_host_model.sv
// bus master model standing in for the host processor
`timescale 1ns/10ps
module vme_host_model (
	input  wire logic        core_clk,
	input  wire logic        dtack_oe,
	input  wire logic [15:0] data_out,
	output logic             as_n,
	output logic             ds0_n,
	output logic             ds1_n,
	output logic             write_n,
	output logic             iack_n,
	output logic             iackin_n,
	output logic [5:0]       am,
	output logic [31:1]      addr,
	output logic [15:0]      data_in
);
	initial begin
		{as_n, ds0_n, ds1_n, write_n, iack_n, iackin_n} = 6'h3f;
		am = 6'h29;
		addr = '0;
		data_in = 16'h0000;
	end
	// request held until acknowledge is sampled; bounded so a dead board cannot hang
	task automatic xfer(input logic w, input logic ia, input logic [31:0] a,
		input logic [15:0] d, output logic [15:0] q, output logic ok);
		ok = 1'b0;
		q = 16'h0000;
		@(posedge core_clk);
		{as_n, ds0_n, ds1_n, iack_n, iackin_n} <= {3'h0, !ia, !ia};
		write_n <= !w;
		addr <= a[31:1];
		data_in <= d;
		for (int i = 0; i < 60 && !ok; i++) begin
			@(posedge core_clk);
			ok = dtack_oe;
			q = data_out;
		end
		{as_n, ds0_n, ds1_n, iack_n, iackin_n} <= 5'h1f;
		data_in <= ~d; // released lines never keep the old value
		addr <= ~a[31:1];
		for (int i = 0; i < 20 && dtack_oe; i++)
			@(posedge core_clk);
	endtask
endmodule // vme_host_model

// ### verification/vme_adc_scan_control_test.sv
// self-checking bench of the converter board control block
`timescale 1ns/10ps
module vme_adc_scan_control_test;
	logic        core_clk = 1'b0;
	logic        srst = 1'b1;
	logic [15:0] adc_result = 16'h0000;
	logic        as_n, ds0_n, ds1_n, write_n, iack_n, iackin_n;
	logic        data_oe, dtack_oe, irq1_oe, iackout_n, sync_trigger_output_n;
	logic        gain_x10, sample_strobe;
	logic [5:0]  am, mux_channel;
	logic [31:1] addr;
	logic [15:0] data_in, data_out;
	logic [31:0] rnd = 32'hf49114ab;
	logic [15:0] exp_q[$];
	logic        gchk = 1'b0;
	logic [5:0]  gch = 6'h00;
	logic        ext_n = 1'b1;
	logic        oe_q = 1'b0;
	int          n_fail = 0;
	int          cmp_count = 0;
	always #4 core_clk = ~core_clk;
	vme_host_model i_vme_host_model (.core_clk(core_clk), .dtack_oe(dtack_oe),
		.data_out(data_out), .as_n(as_n), .ds0_n(ds0_n), .ds1_n(ds1_n), .write_n(write_n),
		.iack_n(iack_n), .iackin_n(iackin_n), .am(am), .addr(addr), .data_in(data_in));
	vme_adc_scan_control i_vme_adc_scan_control (.core_clk(core_clk), .srst(srst),
		.as_n(as_n), .ds0_n(ds0_n), .ds1_n(ds1_n), .write_n(write_n), .iack_n(iack_n),
		.iackin_n(iackin_n), .am(am), .addr(addr), .data_in(data_in),
		.addr_jumpers(20'h0000c), .am_jumpers(6'h29), .external_start_input_n(ext_n),
		.adc_result(adc_result), .data_out(data_out), .data_oe(data_oe), .dtack_n_out(),
		.dtack_oe(dtack_oe), .irq1_n_out(), .irq1_oe(irq1_oe), .iackout_n(iackout_n),
		.sync_trigger_output_n(sync_trigger_output_n), .mux_channel(mux_channel),
		.gain_x10(gain_x10), .sample_strobe(sample_strobe));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [11:0] o, input logic [15:0] d,
		output logic [15:0] q);
		logic ok;
		i_vme_host_model.xfer(w, 1'b0, {16'h0000, 4'hc, o}, d, q, ok);
		chk({15'h0000, ok}, 16'h0001);
		if (!ok)
			close_out();
	endtask
	task automatic wr(input logic [11:0] o, input logic [15:0] d);
		logic [15:0] q;
		bus(1'b1, o, d, q);
	endtask
	task automatic rd(input logic [11:0] o, input logic [15:0] e);
		logic [15:0] q;
		exp_q.push_back(e);
		bus(1'b0, o, 16'h0000, q);
	endtask
	// host waits for the done or ready bit, bounded
	task automatic poll();
		logic [15:0] q;
		for (int i = 0; i < 300; i++) begin
			bus(1'b0, 12'h002, 16'h0000, q);
			if (q[6] === 1'b1)
				return;
		end
		chk(q, 16'h0040);
		close_out();
	endtask
	// output watcher: each read answer takes the oldest noted value
	always @(posedge core_clk) begin
		oe_q <= data_oe;
		if (data_oe && !oe_q && exp_q.size() != 0)
			chk(data_out, exp_q.pop_front());
		if (sample_strobe && gchk) begin
			chk({10'h000, mux_channel}, {10'h000, gch});
			chk({15'h0000, gain_x10}, {15'h0000, gch[0]});
			gch <= gch + 6'h01;
		end
	end
	initial begin
		logic [15:0] v;
		logic [15:0] q;
		logic ok;
		repeat (20) @(posedge core_clk);
		srst <= 1'b0;
		repeat (3) @(posedge core_clk);
		rd(12'h008, 16'hff00);
		rd(12'h010, 16'hff00);
		i_vme_host_model.xfer(1'b0, 1'b0, 32'h00003002, 16'h0000, q, ok);
		chk({15'h0000, ok}, 16'h0000);
		rnd = lfsr(rnd);
		v = rnd[15:0];
		wr(12'h010, v);
		wr(12'h00c, ~v);
		poll();
		rd(12'h006, 16'h007a);
		rd(12'h008, 16'hff00);
		rd(12'h010, v);
		rd(12'h00e, 16'h0000);
		wr(12'h006, 16'h00f7);
		rd(12'h006, 16'h00f7);
		wr(12'h006, 16'h0000); // shortest period keeps the run short
		wr(12'h002, 16'h8000);
		for (int c = 0; c < 16; c++) begin
			wr(12'h004, 16'h0040 | c[15:0]);
			wr(12'h012, {15'h7f80, c[0]});
		end
		wr(12'h004, 16'h0240);
		poll();
		bus(1'b0, 12'h080, 16'h0000, q);
		// the scan begun at reset ignores triggers, so let it reach its block end
		poll();
		bus(1'b0, 12'h080, 16'h0000, q);
		gchk = 1'b1;
		wr(12'h00e, 16'h1234);
		poll();
		gchk = 1'b0;
		wr(12'h004, 16'h588f);
		poll();
		bus(1'b0, 12'h080, 16'h0000, q);
		rnd = lfsr(rnd);
		adc_result <= rnd[31:16];
		wr(12'h008, 16'hff01);
		wr(12'h00e, 16'h0000);
		poll();
		chk({15'h0000, irq1_oe}, 16'h0001);
		exp_q.push_back(v);
		i_vme_host_model.xfer(1'b0, 1'b1, 32'h00000002, 16'h0000, q, ok);
		chk({15'h0000, irq1_oe}, 16'h0000);
		rd(12'h080, rnd[31:16]);
		bus(1'b0, 12'h002, 16'h0000, q);
		chk({15'h0000, q[6]}, 16'h0000);
		wr(12'h008, 16'hff00);
		wr(12'h002, 16'h9800);
		rnd = lfsr(rnd);
		adc_result <= rnd[31:16];
		ext_n <= 1'b0;
		repeat (32) @(posedge core_clk);
		ext_n <= 1'b1;
		poll();
		rd(12'h080, rnd[31:16] ^ 16'h8000);
		close_out();
	end
endmodule // vme_adc_scan_control_test
bind vme_adc_scan_control vme_adc_scan_control_assertions i_vme_adc_scan_control_assertions (
	.core_clk(core_clk), .srst(srst), .as_n(as_n), .ds0_n(ds0_n), .ds1_n(ds1_n),
	.write_n(write_n), .iack_n(iack_n), .iackin_n(iackin_n), .data_out(data_out),
	.data_oe(data_oe), .dtack_oe(dtack_oe), .irq1_oe(irq1_oe), .iackout_n(iackout_n),
	.sync_trigger_output_n(sync_trigger_output_n), .sample_strobe(sample_strobe));
